// ### eirg_params.svh
`ifndef EIRG_PARAMS_SVH
`define EIRG_PARAMS_SVH

// ==========================================
// pin map of the synchronised input vector
`define EIRG_PIN_W        6
`define EIRG_PIN_PORT_LO  0
`define EIRG_PIN_PORT_HI  3
`define EIRG_PIN_IRQ      4
`define EIRG_PIN_RST      5
`define EIRG_PIN_IDLE     6'h30

// ==========================================
// register indices, byte address is index times four
`define EIRG_IDX_TSC      6'h08
`define EIRG_IDX_ISC      6'h0a
`define EIRG_IDX_CCR      6'h0c

// ==========================================
// ext_interrupt_status_control fields
`define EIRG_B_IEN        7
`define EIRG_B_IFLAG      3
`define EIRG_B_IACK       1

// ==========================================
// timer_status_control fields
`define EIRG_B_TOF        7
`define EIRG_B_REALTIME_FLAG       6
`define EIRG_B_TOFE       5
`define EIRG_B_RTIE       4
`define EIRG_B_TOFR       3
`define EIRG_B_RTIFR      2

// ==========================================
// condition_code_register mirror field
`define EIRG_B_IMASK      3

// ==========================================
// vectors and reset values
`define EIRG_VEC_EXT      10'h03fa
`define EIRG_VEC_TMR      10'h03f8
`define EIRG_RST_IEN      1'b1
`define EIRG_RST_IMASK    1'b1
`define EIRG_RST_FLAG     1'b0

`endif

// ### eirg_pkg.sv
package eirg_pkg;

  typedef struct packed {
    logic [5:0] s1;
    logic [5:0] s2;
    logic [5:0] s3;
    logic [5:0] flt;
    logic [5:0] prv;
  } eirg_sync_t;

  typedef struct packed {
    logic latch;
    logic out;
  } eirg_rst_t;

  typedef struct packed {
    logic       timer_overflow_flag;
    logic       realtime_flag;
    logic       tofe;
    logic       rtie;
    logic       ien;
    logic       latch;
    logic       pend;
    logic       inhib;
    logic       imask;
    logic       or_prev;
    logic       pin_lvl;
    logic       req;
    logic [9:0] vec;
    logic       waitreq;
    logic [7:0] rdata;
  } eirg_top_t;

endpackage

// ### eirg_pin_if.sv
`timescale 1ns/1ps
interface eirg_pin_if;
  logic [5:0] lvl;
  logic [5:0] rise;
  modport src (output lvl, output rise);
  modport dst (input lvl, input rise);
endinterface

// ### eirg_sync.sv
`timescale 1ns/1ps
`include "eirg_params.svh"
module eirg_sync
  import eirg_pkg::*;
(
  input  wire logic                   sys_clk,
  input  wire logic                   rst_b,
  input  wire logic [`EIRG_PIN_W-1:0] pins_async,
  eirg_pin_if.src                     pif
);

  eirg_sync_t r;
  eirg_sync_t n;

  // ==========================================
  // three stages, level accepted when stages two and three agree
  always_comb begin
    n     = r;
    n.s1  = pins_async;
    n.s2  = r.s1;
    n.s3  = r.s2;
    n.flt = (~(r.s2 ^ r.s3) & r.s3) | ((r.s2 ^ r.s3) & r.flt);
    n.prv = r.flt;
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      r <= '{s1: `EIRG_PIN_IDLE, s2: `EIRG_PIN_IDLE, s3: `EIRG_PIN_IDLE,
             flt: `EIRG_PIN_IDLE, prv: `EIRG_PIN_IDLE};
    end else begin
      r <= n;
    end
  end

  assign pif.lvl  = r.flt;
  assign pif.rise = r.flt & ~r.prv;

endmodule

// ### eirg_rst.sv
`timescale 1ns/1ps
`include "eirg_params.svh"
module eirg_rst
  import eirg_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic rst_b,
  eirg_pin_if.dst   pif,
  input  wire logic por_req,
  input  wire logic cop_req,
  input  wire logic iladr_req,
  output logic      dev_rst
);

  eirg_rst_t r;
  eirg_rst_t n;

  // ==========================================
  // reset latch, held while any source is active
  always_comb begin
    n       = r;
    n.latch = ~pif.lvl[`EIRG_PIN_RST] | por_req | cop_req | iladr_req;
    n.out   = r.latch;
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      r <= '{latch: 1'b1, out: 1'b1};
    end else begin
      r <= n;
    end
  end

  assign dev_rst = r.out;

endmodule

// ### eirg_top.sv
`timescale 1ns/1ps
`include "eirg_params.svh"
module eirg_top
  import eirg_pkg::*;
#(
  parameter bit EDGE_LEVEL  = 1'b0,
  parameter bit PORT_IRQ_EN = 1'b0
)(
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        irq_pin_b,
  input  wire logic [3:0]  low_port_pins,
  input  wire logic        reset_pin_b,
  input  wire logic        por_req,
  input  wire logic        cop_req,
  input  wire logic        iladr_req,
  input  wire logic        timer_overflow_evt,
  input  wire logic        realtime_evt,
  input  wire logic        cpu_vector_fetch,
  input  wire logic        cpu_stop_wait,
  output logic             int_request,
  output logic      [9:0]  int_vector,
  output logic             branch_pin_level,
  output logic             device_reset
);

  // ==========================================
  // pin synchronisation and reset latch
  eirg_pin_if pif ();

  eirg_sync u_sync (
    .sys_clk    (sys_clk),
    .rst_b      (rst_b),
    .pins_async ({reset_pin_b, irq_pin_b, low_port_pins}),
    .pif        (pif.src)
  );

  eirg_rst u_rst (
    .sys_clk   (sys_clk),
    .rst_b     (rst_b),
    .pif       (pif.dst),
    .por_req   (por_req),
    .cop_req   (cop_req),
    .iladr_req (iladr_req),
    .dev_rst   (device_reset)
  );

  // ==========================================
  // state
  eirg_top_t r;
  eirg_top_t n;

  logic       or_in;
  logic       edge_hit;
  logic       level_hit;
  logic [5:0] idx;
  logic       addr_ok;
  logic       hit_tsc;
  logic       hit_isc;
  logic       hit_ccr;
  logic       wr_go;
  logic       rd_start;
  logic       ack_wr;
  logic       ext_fetch;
  logic       ext_clr;
  logic       ext_go;
  logic       tmr_go;
  logic [7:0] wd;

  // ==========================================
  // next state
  always_comb begin
    n = r;

    // ------------------------------------------
    // bus decode
    idx      = avs_address[7:2];
    addr_ok  = (avs_address[1:0] == 2'h0);
    hit_tsc  = addr_ok && (idx == `EIRG_IDX_TSC);
    hit_isc  = addr_ok && (idx == `EIRG_IDX_ISC);
    hit_ccr  = addr_ok && (idx == `EIRG_IDX_CCR);
    wd       = avs_writedata[7:0];
    wr_go    = avs_write & ~r.waitreq;
    rd_start = avs_read & r.waitreq;

    // ------------------------------------------
    // external source merge and edge detection
    or_in    = ~pif.lvl[`EIRG_PIN_IRQ]
               | (PORT_IRQ_EN & (|pif.lvl[`EIRG_PIN_PORT_HI:`EIRG_PIN_PORT_LO]));
    edge_hit = or_in & ~r.or_prev;
    n.or_prev = or_in;
    n.pin_lvl = pif.lvl[`EIRG_PIN_IRQ];

    // ------------------------------------------
    // acknowledge and vector fetch clears
    ack_wr    = wr_go & hit_isc & wd[`EIRG_B_IACK];
    ext_fetch = cpu_vector_fetch & r.req & (r.vec == `EIRG_VEC_EXT);
    ext_clr   = ack_wr | ext_fetch;

    // new edge in the clearing cycle wins
    n.latch = edge_hit | (r.latch & ~ext_clr);

    // level path held off after a clear until the sources go inactive
    n.inhib   = EDGE_LEVEL & or_in & (ext_clr | r.inhib);
    level_hit = EDGE_LEVEL & or_in & ~(ext_clr | r.inhib);

    // pending flag set by hardware only, never by a bus write; the acknowledge write clears it
    n.pend = n.latch | level_hit;

    // ------------------------------------------
    // enable bit
    if (wr_go && hit_isc) begin
      n.ien = wd[`EIRG_B_IEN];
    end
    if (cpu_stop_wait) begin
      n.ien = 1'b1;
    end

    // ------------------------------------------
    // timer flags, set wins over write-one clear
    if (wr_go && hit_tsc) begin
      n.tofe = wd[`EIRG_B_TOFE];
      n.rtie = wd[`EIRG_B_RTIE];
    end
    n.timer_overflow_flag  = timer_overflow_evt
             | (r.timer_overflow_flag & ~(wr_go & hit_tsc & wd[`EIRG_B_TOFR]));
    n.realtime_flag = realtime_evt
             | (r.realtime_flag & ~(wr_go & hit_tsc & wd[`EIRG_B_RTIFR]));

    // ------------------------------------------
    // global mask mirror
    if (wr_go && hit_ccr) begin
      n.imask = wd[`EIRG_B_IMASK];
    end
    if (cpu_stop_wait) begin
      n.imask = 1'b0;
    end
    if (cpu_vector_fetch && r.req) begin
      n.imask = 1'b1;
    end

    // ------------------------------------------
    // request and priority
    ext_go = n.pend & n.ien & ~n.imask;
    tmr_go = ((n.timer_overflow_flag & n.tofe) | (n.realtime_flag & n.rtie)) & ~n.imask;
    n.req  = ext_go | tmr_go;
    if (ext_go) begin
      n.vec = `EIRG_VEC_EXT;
    end else if (tmr_go) begin
      n.vec = `EIRG_VEC_TMR;
    end else begin
      n.vec = r.vec;
    end

    // ------------------------------------------
    // bus handshake, one wait cycle per access
    n.waitreq = ~((avs_read | avs_write) & r.waitreq);
    if (rd_start) begin
      n.rdata = 8'h00;
      if (hit_isc) begin
        n.rdata[`EIRG_B_IEN]   = r.ien;
        n.rdata[`EIRG_B_IFLAG] = r.pend;
      end else if (hit_tsc) begin
        n.rdata[`EIRG_B_TOF]  = r.timer_overflow_flag;
        n.rdata[`EIRG_B_REALTIME_FLAG] = r.realtime_flag;
        n.rdata[`EIRG_B_TOFE] = r.tofe;
        n.rdata[`EIRG_B_RTIE] = r.rtie;
      end else if (hit_ccr) begin
        n.rdata[`EIRG_B_IMASK] = r.imask;
      end
    end

    // ------------------------------------------
    // device reset from the reset latch
    if (device_reset) begin
      n.pend    = `EIRG_RST_FLAG;
      n.latch   = 1'b0;
      n.inhib   = 1'b0;
      n.ien     = `EIRG_RST_IEN;
      n.imask   = `EIRG_RST_IMASK;
      n.timer_overflow_flag     = 1'b0;
      n.realtime_flag    = 1'b0;
      n.tofe    = 1'b0;
      n.rtie    = 1'b0;
      n.req     = 1'b0;
      n.vec     = `EIRG_VEC_TMR;
    end
  end

  // ==========================================
  // registers
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      r.timer_overflow_flag     <= 1'b0;
      r.realtime_flag    <= 1'b0;
      r.tofe    <= 1'b0;
      r.rtie    <= 1'b0;
      r.ien     <= `EIRG_RST_IEN;
      r.latch   <= 1'b0;
      r.pend    <= `EIRG_RST_FLAG;
      r.inhib   <= 1'b0;
      r.imask   <= `EIRG_RST_IMASK;
      r.or_prev <= 1'b0;
      r.pin_lvl <= 1'b1;
      r.req     <= 1'b0;
      r.vec     <= `EIRG_VEC_TMR;
      r.waitreq <= 1'b1;
      r.rdata   <= 8'h00;
    end else begin
      r <= n;
    end
  end

  // ==========================================
  // outputs
  assign avs_readdata     = {24'h00_0000, r.rdata};
  assign avs_waitrequest  = r.waitreq;
  assign int_request      = r.req;
  assign int_vector       = r.vec;
  assign branch_pin_level = r.pin_lvl;

endmodule

// ### eirg_monitor.sv
`timescale 1ns/1ps
// ====================================
// port checker for eirg_top
module eirg_monitor (
  input wire logic        sys_clk,
  input wire logic        rst_b,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        irq_pin_b,
  input wire logic        reset_pin_b,
  input wire logic        cpu_vector_fetch,
  input wire logic        int_request,
  input wire logic [9:0]  int_vector,
  input wire logic        branch_pin_level,
  input wire logic        device_reset
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  a_bus_one_wait: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus access not answered after one cycle");
  a_rd_upper: assert property (
    avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h00_0000)
    else $error("read data upper bits not zero");
  a_fetch_drop: assert property (
    int_request && cpu_vector_fetch && int_vector == 10'h3fa |=> ##[0:1] !int_request)
    else $error("request still high after vector fetch");
  a_req_hold: assert property (
    int_request && !avs_write && !$past(avs_write) && !cpu_vector_fetch
    && !$past(cpu_vector_fetch) && !$past(cpu_vector_fetch, 2) && !device_reset
    |=> int_request)
    else $error("request dropped without a cause");
  a_vec_legal: assert property (
    int_request |-> int_vector == 10'h3fa || int_vector == 10'h3f8)
    else $error("request with unknown vector");
  a_rst_hold: assert property (
    !reset_pin_b [*8] |-> device_reset)
    else $error("device not held in reset by reset pin");
  a_rst_quiet: assert property (
    device_reset [*3] |-> !int_request)
    else $error("request raised during device reset");
  a_pin_high: assert property (
    irq_pin_b [*8] |-> branch_pin_level)
    else $error("branch level not high for high pin");
  a_pin_low: assert property (
    !irq_pin_b [*8] |-> !branch_pin_level)
    else $error("branch level not low for low pin");
endmodule

bind eirg_top eirg_monitor u_eirg_monitor (.sys_clk, .rst_b, .avs_read, .avs_write,
  .avs_readdata, .avs_waitrequest, .irq_pin_b, .reset_pin_b, .cpu_vector_fetch,
  .int_request, .int_vector, .branch_pin_level, .device_reset);

// ### eirg_cpu_model.sv
`timescale 1ns/1ps
// ====================================
// cpu sequencer: fetches a vector lag+1 cycles after a request
module eirg_cpu_model (
  input  wire logic       sys_clk,
  input  wire logic       rst_b,
  input  wire logic [3:0] lag,
  input  wire logic       int_request,
  input  wire logic [9:0] int_vector,
  output logic            cpu_vector_fetch,
  output logic [9:0]      last_vec
);
  logic [3:0] wait_cnt;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cpu_vector_fetch <= 1'b0;
      last_vec <= 10'h000;
      wait_cnt <= 4'h0;
    end else begin
      cpu_vector_fetch <= 1'b0;
      wait_cnt <= 4'h0;
      if (int_request && !cpu_vector_fetch) begin
        wait_cnt <= wait_cnt + 4'h1;
        if (wait_cnt >= lag) begin
          cpu_vector_fetch <= 1'b1;
          last_vec <= int_vector;
          wait_cnt <= 4'h0;
        end
      end
    end
  end
endmodule

// ### testbench.sv
`timescale 1ns/1ps
module testbench;
  logic        sys_clk = 1'b0;
  logic        rst_b = 1'b0;
  logic [7:0]  avs_address = 8'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        irq_pin_b = 1'b1;
  logic [3:0]  low_port_pins = 4'h0;
  logic        reset_pin_b = 1'b1;
  logic        por_req = 1'b0;
  logic        cop_req = 1'b0;
  logic        iladr_req = 1'b0;
  logic        timer_overflow_evt = 1'b0;
  logic        realtime_evt = 1'b0;
  logic        cpu_stop_wait = 1'b0;
  logic        cpu_vector_fetch;
  logic        int_request;
  logic [9:0]  int_vector;
  logic        branch_pin_level;
  logic        device_reset;
  logic [3:0]  lag = 4'h0;
  logic [9:0]  last_vec;
  logic [31:0] rd;
  int          fail_count = 0;
  int          cmp_count = 0;
  logic [23:0] rows [9] = '{24'h28_ff80, 24'h28_0000, 24'h20_3030, 24'h20_0000,
    24'h30_0808, 24'h3c_ff00, 24'h29_ff00, 24'h30_0000, 24'h28_8080};

  always #25 sys_clk = ~sys_clk;

  eirg_top #(.EDGE_LEVEL(1'b0), .PORT_IRQ_EN(1'b1)) u_eirg_top (.sys_clk, .rst_b,
    .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
    .avs_waitrequest, .irq_pin_b, .low_port_pins, .reset_pin_b, .por_req, .cop_req,
    .iladr_req, .timer_overflow_evt, .realtime_evt, .cpu_vector_fetch, .cpu_stop_wait,
    .int_request, .int_vector, .branch_pin_level, .device_reset);

  eirg_cpu_model u_eirg_cpu_model (.sys_clk, .rst_b, .lag, .int_request, .int_vector,
    .cpu_vector_fetch, .last_vec);

  // ====================================
  // shared tasks
  task automatic complete_run();
    if (fail_count == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic bus(input logic [7:0] a, input logic wr, input logic [7:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= {24'h00_0000, d};
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    if (n >= 20) begin
      check(32'(avs_waitrequest), 32'h0000_0000);
      complete_run();
    end
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(a, 1'b1, d);
  endtask

  task automatic rdr(input logic [7:0] a);
    bus(a, 1'b0, 8'h00);
  endtask

  task automatic wait_bit(input int sel, input logic v);
    int n;
    n = 0;
    while (((sel == 0) ? int_request : device_reset) !== v) begin
      @(posedge sys_clk);
      n++;
      if (n > 300) begin
        check(32'(n), 32'h0000_0000);
        complete_run();
      end
    end
  endtask

  task automatic hold_low(input int k);
    repeat (k) begin
      @(posedge sys_clk);
      check(32'(int_request), 32'h0000_0000);
    end
  endtask

  // ====================================
  // main sequence
  initial begin
    repeat (4) @(posedge sys_clk);
    rst_b <= 1'b1;
    wait_bit(1, 1'b0);
    foreach (rows[i]) begin
      wr(rows[i][23:16], rows[i][15:8]);
      rdr(rows[i][23:16]);
      check(rd, {24'h00_0000, rows[i][7:0]});
    end
    wr(8'h30, 8'h08);
    irq_pin_b <= 1'b0;
    hold_low(12);
    rdr(8'h28);
    check(rd, 32'h0000_0088);
    irq_pin_b <= 1'b1;
    wr(8'h30, 8'h00);
    wait_bit(0, 1'b1);
    check(32'(int_vector), 32'h0000_03fa);
    wait_bit(0, 1'b0);
    rdr(8'h28);
    check(rd, 32'h0000_0080);
    for (int i = 0; i < 5; i++) begin
      wr(8'h30, 8'h00);
      low_port_pins <= (i < 4) ? 4'h1 << i : 4'h0;
      irq_pin_b <= (i < 4);
      wait_bit(0, 1'b1);
      check(32'(int_vector), 32'h0000_03fa);
      wait_bit(0, 1'b0);
      low_port_pins <= 4'h0;
      irq_pin_b <= 1'b1;
      repeat (8) @(posedge sys_clk);
    end
    low_port_pins <= 4'h1;
    repeat (8) @(posedge sys_clk);
    wr(8'h28, 8'h80);
    rdr(8'h28);
    check(rd, 32'h0000_0088);
    wr(8'h28, 8'h82);
    rdr(8'h28);
    check(rd, 32'h0000_0080);
    low_port_pins <= 4'h3;
    repeat (8) @(posedge sys_clk);
    check(32'(branch_pin_level), 32'h0000_0001);
    rdr(8'h28);
    check(rd, 32'h0000_0080);
    low_port_pins <= 4'h0;
    wr(8'h28, 8'h00);
    wr(8'h30, 8'h00);
    irq_pin_b <= 1'b0;
    hold_low(10);
    irq_pin_b <= 1'b1;
    wr(8'h28, 8'h80);
    wait_bit(0, 1'b1);
    wait_bit(0, 1'b0);
    wr(8'h28, 8'h00);
    cpu_stop_wait <= 1'b1;
    @(posedge sys_clk);
    cpu_stop_wait <= 1'b0;
    rdr(8'h28);
    check(rd, 32'h0000_0080);
    rdr(8'h30);
    check(rd, 32'h0000_0000);
    wr(8'h30, 8'h08);
    wr(8'h20, 8'h30);
    {timer_overflow_evt, realtime_evt} <= 2'b11;
    irq_pin_b <= 1'b0;
    @(posedge sys_clk);
    {timer_overflow_evt, realtime_evt} <= 2'b00;
    repeat (8) @(posedge sys_clk);
    irq_pin_b <= 1'b1;
    rdr(8'h20);
    check(rd, 32'h0000_00f0);
    lag <= 4'h5;
    wr(8'h30, 8'h00);
    wait_bit(0, 1'b1);
    check(32'(int_vector), 32'h0000_03fa);
    wait_bit(0, 1'b0);
    wr(8'h30, 8'h00);
    wait_bit(0, 1'b1);
    check(32'(int_vector), 32'h0000_03f8);
    wait_bit(0, 1'b0);
    check(32'(last_vec), 32'h0000_03f8);
    lag <= 4'h0;
    wr(8'h20, 8'h3c);
    rdr(8'h20);
    check(rd, 32'h0000_0030);
    wr(8'h30, 8'h00);
    hold_low(8);
    for (int i = 0; i < 4; i++) begin
      wr(8'h28, 8'h00);
      reset_pin_b <= (i != 0);
      {iladr_req, cop_req, por_req} <= (i == 0) ? 3'h0 : 3'h1 << (i - 1);
      wait_bit(1, 1'b1);
      repeat (12) @(posedge sys_clk);
      check(32'(device_reset), 32'h0000_0001);
      reset_pin_b <= 1'b1;
      {iladr_req, cop_req, por_req} <= 3'h0;
      wait_bit(1, 1'b0);
      rdr(8'h28);
      check(rd, 32'h0000_0080);
      rdr(8'h30);
      check(rd, 32'h0000_0008);
    end
    rst_b <= 1'b0;
    repeat (2) @(posedge sys_clk);
    check(32'(avs_waitrequest), 32'h0000_0001);
    check(avs_readdata, 32'h0000_0000);
    check(32'(int_request), 32'h0000_0000);
    check(32'(int_vector), 32'h0000_03f8);
    check(32'(branch_pin_level), 32'h0000_0001);
    check(32'(device_reset), 32'h0000_0001);
    rst_b <= 1'b1;
    wait_bit(1, 1'b0);
    rdr(8'h28);
    check(rd, 32'h0000_0080);
    complete_run();
  end
endmodule
